/* rtl/gpt_pkg.sv */
// Register map, field layouts, reset values and carrier types of the timers.
`default_nettype none

package gpt_pkg;

  // ---------------------------------------------------------------
  // Timer units and the low-timer set
  // ---------------------------------------------------------------
  localparam int NTMR = 5;
  localparam int T_A  = 0;
  localparam int T_BL = 1;
  localparam int T_BH = 2;
  localparam int T_CL = 3;
  localparam int T_CH = 4;
  localparam logic [4:0] LOW_SET = 5'h0a;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_HOLD_B = 8'h50;
  localparam logic [7:0] OFS_HOLD_C = 8'h54;
  localparam logic [7:0] OFS_STATUS = 8'h58;
  localparam logic [7:0] OFS_MASK   = 8'h5c;

  // Kinds of register inside each 16-byte timer slot.
  localparam logic [1:0] KIND_CTRL = 2'h0;
  localparam logic [1:0] KIND_PER  = 2'h1;
  localparam logic [1:0] KIND_CNT  = 2'h2;
  localparam logic [1:0] KIND_MISC = 2'h3;

  // Slot numbers of the miscellaneous registers.
  localparam logic [2:0] MISC_HOLD_B = 3'h0;
  localparam logic [2:0] MISC_HOLD_C = 3'h1;
  localparam logic [2:0] MISC_STATUS = 3'h2;
  localparam logic [2:0] MISC_MASK   = 3'h3;

  // ---------------------------------------------------------------
  // Reset values and writable bits
  // ---------------------------------------------------------------
  localparam logic [15:0] CTRL_RST     = 16'h0000;
  localparam logic [15:0] PER_RST      = 16'hffff;
  localparam logic [15:0] CNT_RST      = 16'h0000;
  localparam logic [15:0] HOLD_RST     = 16'h0000;
  localparam logic [4:0]  STAT_RST     = 5'h00;
  localparam logic [4:0]  MASK_RST     = 5'h00;
  localparam logic [15:0] WMASK_A      = 16'ha076;
  localparam logic [15:0] WMASK_LOW    = 16'ha07a;
  localparam logic [15:0] WMASK_HIGH   = 16'ha072;

  // Prescaler terminal counts for ratios 1, 8, 64 and 256.
  localparam logic [7:0] PS_TOP_1   = 8'h00;
  localparam logic [7:0] PS_TOP_8   = 8'h07;
  localparam logic [7:0] PS_TOP_64  = 8'h3f;
  localparam logic [7:0] PS_TOP_256 = 8'hff;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       en;
    logic       rsv14;
    logic       stop_in_idle;
    logic [5:0] rsv12;
    logic       gate_en;
    logic [1:0] prescale;
    logic       chain32;
    logic       sync_ext;
    logic       clk_ext;
    logic       rsv0;
  } gpt_ctrl_s;

  typedef struct packed {
    logic       ok;
    logic [2:0] idx;
    logic [1:0] kind;
  } gpt_dec_s;

endpackage

`default_nettype wire

/* rtl/gpt_timers.sv */
// Five general purpose timer units behind an AXI4-Lite register slave.
`timescale 1ns/1ns
`default_nettype none

module gpt_timers
  import gpt_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cpu_idle,
  input  wire logic [4:0]  tmr_ext_in,
  output var  logic        irq,
  output var  logic        adc_trigger,
  output var  logic [15:0] tb_low,
  output var  logic [15:0] tb_high
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // Splits a byte address into timer slot and register kind.
  function automatic gpt_dec_s decode(input logic [7:0] a);
    gpt_dec_s d;
    d = '0;
    if (a < OFS_HOLD_B) begin
      d.idx  = a[6:4];
      d.kind = a[3:2];
      d.ok   = (a[6:4] < 3'h5) && (a[3:2] != KIND_MISC);
    end else if (a == OFS_HOLD_B) begin
      d = '{ok: 1'b1, idx: MISC_HOLD_B, kind: KIND_MISC};
    end else if (a == OFS_HOLD_C) begin
      d = '{ok: 1'b1, idx: MISC_HOLD_C, kind: KIND_MISC};
    end else if (a == OFS_STATUS) begin
      d = '{ok: 1'b1, idx: MISC_STATUS, kind: KIND_MISC};
    end else if (a == OFS_MASK) begin
      d = '{ok: 1'b1, idx: MISC_MASK, kind: KIND_MISC};
    end
    return d;
  endfunction

  // Replaces the byte lanes of a 16-bit value that the strobes select.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0]  strb);
    return {strb[1] ? nw[15:8] : old[15:8],
            strb[0] ? nw[7:0]  : old[7:0]};
  endfunction

  // Terminal count of the prescaler for a ratio field.
  function automatic logic [7:0] ps_top(input logic [1:0] ps);
    case (ps)
      2'h0:    return PS_TOP_1;
      2'h1:    return PS_TOP_8;
      2'h2:    return PS_TOP_64;
      default: return PS_TOP_256;
    endcase
  endfunction

  // Control bits that exist for a given timer.
  function automatic logic [15:0] ctrl_wmask(input logic [2:0] i);
    if (i == 3'(T_A)) begin
      return WMASK_A;
    end else if (LOW_SET[i]) begin
      return WMASK_LOW;
    end else begin
      return WMASK_HIGH;
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  gpt_ctrl_s   ctrl_q [NTMR];
  logic [15:0] per_q  [NTMR];
  logic [15:0] cnt_q  [NTMR];
  logic [15:0] cnt_d  [NTMR];
  logic [7:0]  pre_q  [NTMR];
  logic [7:0]  pre_d  [NTMR];
  logic [15:0] hold_q [2];
  logic [4:0]  stat_q;
  logic [4:0]  stat_d;
  logic [4:0]  mask_q;
  logic [4:0]  sync1_q;
  logic [4:0]  sync2_q;
  logic [4:0]  sync3_q;
  logic [4:0]  pin_prev_q;
  logic [4:0]  tick_sync_q;
  logic        irq_q;
  logic        adc_q;
  logic        awready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  // Per-timer combinational terms.
  logic [4:0]  ev;
  logic [4:0]  run;
  logic [4:0]  pre_hit;
  logic [4:0]  tick;
  logic [4:0]  gated;
  logic [4:0]  chained;
  logic [4:0]  gate_fall;
  logic [4:0]  match_ev;
  logic [4:0]  set_ev;
  logic [31:0] c32;
  logic [31:0] p32;
  logic [31:0] n32;
  logic        hit16;
  logic        hit32;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------

  // Write and read strobes, and the registers they address.
  gpt_dec_s    wdec;
  gpt_dec_s    rdec;
  logic        wr_go;
  logic        wr_fire;
  logic        rd_go;
  logic        rd_fire;
  logic [15:0] wdat;
  logic [1:0]  wstb;
  logic [15:0] rd_timer;
  logic [15:0] rd_misc;
  logic [15:0] rd_val;
  logic        rd_stat;
  logic        rd_low_cnt;
  logic        wr_low_cnt;

  assign wdec    = decode(s_axi_awaddr);
  assign rdec    = decode(s_axi_araddr);
  assign wr_go   = s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
  assign rd_go   = s_axi_arvalid & ~arready_q & ~rvalid_q;
  assign wr_fire = awready_q;
  assign rd_fire = arready_q;
  assign wdat    = s_axi_wdata[15:0];
  assign wstb    = s_axi_wstrb[1:0];

  // Read multiplexer; reserved and upper bits read as zero.
  assign rd_timer = (rdec.kind == KIND_CTRL) ? ctrl_q[rdec.idx] :
                    (rdec.kind == KIND_PER)  ? per_q[rdec.idx]  :
                                               cnt_q[rdec.idx];
  assign rd_misc  = (rdec.idx == MISC_HOLD_B) ? hold_q[0] :
                    (rdec.idx == MISC_HOLD_C) ? hold_q[1] :
                    (rdec.idx == MISC_STATUS) ? {11'h000, stat_q} :
                                                {11'h000, mask_q};
  assign rd_val   = !rdec.ok ? 16'h0000 :
                    (rdec.kind == KIND_MISC) ? rd_misc : rd_timer;

  // Side-effecting reads and writes.
  assign rd_stat    = rd_fire & rdec.ok & (rdec.kind == KIND_MISC) &
                      (rdec.idx == MISC_STATUS);
  assign rd_low_cnt = rd_fire & rdec.ok & (rdec.kind == KIND_CNT) &
                      LOW_SET[rdec.idx];
  assign wr_low_cnt = wr_fire & wdec.ok & (wdec.kind == KIND_CNT) &
                      LOW_SET[wdec.idx];

  // ---------------------------------------------------------------
  // Clock sources and prescalers
  // ---------------------------------------------------------------

  // Picks each timer's count event, then divides it down.
  always_comb begin
    for (int i = 0; i < NTMR; i++) begin
      gated[i] = ctrl_q[i].gate_en & ~ctrl_q[i].clk_ext;
      run[i]   = ctrl_q[i].en & ~(cpu_idle & ctrl_q[i].stop_in_idle);
      gate_fall[i] = gated[i] & ctrl_q[i].en & sync3_q[i] & ~sync2_q[i];
      if (ctrl_q[i].clk_ext) begin
        if (i == T_A && !ctrl_q[i].sync_ext) begin
          ev[i] = tmr_ext_in[i] & ~pin_prev_q[i];
        end else begin
          ev[i] = sync2_q[i] & ~sync3_q[i];
        end
      end else if (gated[i]) begin
        ev[i] = sync2_q[i];
      end else begin
        ev[i] = 1'b1;
      end
      pre_hit[i] = ev[i] & run[i] &
                   (pre_q[i] == ps_top(ctrl_q[i].prescale));
      pre_d[i] = pre_q[i];
      if (!ctrl_q[i].en) begin
        pre_d[i] = 8'h00;
      end else if (ev[i] & run[i]) begin
        pre_d[i] = pre_hit[i] ? 8'h00 : pre_q[i] + 8'h01;
      end
    end
  end

  // Low timers see their prescaler output one register later.
  assign tick    = (pre_hit & ~LOW_SET) | tick_sync_q;
  assign chained = {ctrl_q[T_CL].chain32, ctrl_q[T_CL].chain32,
                    ctrl_q[T_BL].chain32, ctrl_q[T_BL].chain32,
                    1'b0};

  // ---------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------

  // Next count of every timer, then software writes on top.
  always_comb begin
    match_ev = 5'h00;
    set_ev   = 5'h00;
    c32      = 32'h0000_0000;
    p32      = 32'h0000_0000;
    n32      = 32'h0000_0000;
    hit16    = 1'b0;
    hit32    = 1'b0;
    for (int i = 0; i < NTMR; i++) begin
      cnt_d[i] = cnt_q[i];
      // Independent 16-bit operation.
      if (!chained[i] && tick[i]) begin
        hit16 = ~gated[i] & (cnt_q[i] == per_q[i]);
        cnt_d[i] = hit16 ? CNT_RST : cnt_q[i] + 16'h0001;
        match_ev[i] = hit16;
      end
      if (!chained[i]) begin
        set_ev[i] = set_ev[i] | gate_fall[i];
      end
    end
    // Chained 32-bit operation of each pair.
    for (int p = 0; p < 2; p++) begin
      if (chained[2 * p + 1]) begin
        c32 = {cnt_q[2 * p + 2], cnt_q[2 * p + 1]};
        p32 = {per_q[2 * p + 2], per_q[2 * p + 1]};
        if (tick[2 * p + 1]) begin
          hit32 = ~gated[2 * p + 1] & (c32 == p32);
          n32   = hit32 ? 32'h0000_0000 : c32 + 32'h0000_0001;
          cnt_d[2 * p + 1] = n32[15:0];
          cnt_d[2 * p + 2] = n32[31:16];
          match_ev[2 * p + 2] = hit32;
        end
        set_ev[2 * p + 2] = set_ev[2 * p + 2] | gate_fall[2 * p + 1];
      end
    end
    set_ev = set_ev | match_ev;
    // Software count writes; a chained low write loads the high word.
    if (wr_fire && wdec.ok && wdec.kind == KIND_CNT) begin
      cnt_d[wdec.idx] = merge16(cnt_q[wdec.idx], wdat, wstb);
      if (wr_low_cnt && chained[wdec.idx]) begin
        cnt_d[wdec.idx + 3'h1] = hold_q[wdec.idx[1]];
      end
    end
  end

  // Sticky status: a new event wins over the clearing read.
  assign stat_d = (stat_q & ~{5{rd_stat}}) | set_ev;

  // ---------------------------------------------------------------
  // Timer registers
  // ---------------------------------------------------------------

  // Input synchronizers, edge history and the low-timer tick stage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q     <= 5'h00;
      sync2_q     <= 5'h00;
      sync3_q     <= 5'h00;
      pin_prev_q  <= 5'h00;
      tick_sync_q <= 5'h00;
    end else begin
      sync1_q     <= tmr_ext_in;
      sync2_q     <= sync1_q;
      sync3_q     <= sync2_q;
      pin_prev_q  <= tmr_ext_in;
      tick_sync_q <= pre_hit & LOW_SET;
    end
  end

  // Control, period, count and prescaler state of each timer.
  always_ff @(posedge aclk) begin
    for (int i = 0; i < NTMR; i++) begin
      if (!aresetn) begin
        ctrl_q[i] <= gpt_ctrl_s'(CTRL_RST);
        per_q[i]  <= PER_RST;
        cnt_q[i]  <= CNT_RST;
        pre_q[i]  <= 8'h00;
      end else begin
        cnt_q[i] <= cnt_d[i];
        pre_q[i] <= pre_d[i];
        if (wr_fire && wdec.ok && wdec.idx == 3'(i)) begin
          if (wdec.kind == KIND_CTRL) begin
            ctrl_q[i] <= gpt_ctrl_s'(merge16(ctrl_q[i], wdat, wstb) &
                                     ctrl_wmask(3'(i)));
          end else if (wdec.kind == KIND_PER) begin
            per_q[i] <= merge16(per_q[i], wdat, wstb);
          end
        end
      end
    end
  end

  // Holding registers: a write wins over a same-cycle read capture.
  always_ff @(posedge aclk) begin
    for (int p = 0; p < 2; p++) begin
      if (!aresetn) begin
        hold_q[p] <= HOLD_RST;
      end else if (wr_fire && wdec.ok && wdec.kind == KIND_MISC &&
                   wdec.idx == 3'(p)) begin
        hold_q[p] <= merge16(hold_q[p], wdat, wstb);
      end else if (rd_low_cnt && rdec.idx[1] == p[0]) begin
        hold_q[p] <= cnt_q[rdec.idx + 3'h1];
      end
    end
  end

  // Status, mask, interrupt line and the ADC trigger from the T_BH match.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q  <= STAT_RST;
      mask_q  <= MASK_RST;
      irq_q   <= 1'b0;
      adc_q   <= 1'b0;
    end else begin
      stat_q <= stat_d;
      if (wr_fire && wdec.ok && wdec.kind == KIND_MISC &&
          wdec.idx == MISC_MASK && wstb[0]) begin
        mask_q <= wdat[4:0];
      end
      irq_q <= |(stat_q & mask_q);
      adc_q <= match_ev[T_BH];
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite handshakes
  // ---------------------------------------------------------------

  // Write channel: address and data taken together, then a response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      awready_q <= wr_go;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wdec.ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel: data is sampled in the cycle the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else begin
      arready_q <= rd_go;
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rdec.ok ? RESP_OKAY : RESP_SLVERR;
        rdata_q  <= {16'h0000, rd_val};
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = awready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign irq           = irq_q;
  assign adc_trigger   = adc_q;
  assign tb_low        = cnt_q[T_BL];
  assign tb_high       = cnt_q[T_BH];

endmodule

`default_nettype wire

/* verif/gpt_timers_chk.sv */
// Port-level bus and trigger checks for the general purpose timers.
`timescale 1ns/1ns
`default_nettype none

module gpt_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        adc_trigger
);
  // ---------------------------------------------------------------
  // Handshake timing of the register slave, zero upper read data and the trigger pulse width
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_aw_take: assert property (s_axi_awvalid && s_axi_wvalid &&
    !s_axi_awready && !s_axi_bvalid |=> s_axi_awready)
    else $error("write request not taken");
  a_ready_pulse: assert property (s_axi_awready |->
    s_axi_wready ##1 !s_axi_awready && !s_axi_wready)
    else $error("write ready not a paired pulse");
  a_b_answer: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("write answer late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
  a_ar_take: assert property (s_axi_arvalid && !s_axi_arready &&
    !s_axi_rvalid |=> s_axi_arready ##1 s_axi_rvalid)
    else $error("read not taken or answered");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_adc_pulse: assert property ($rose(adc_trigger) |=> !adc_trigger)
    else $error("trigger longer than one cycle");
endmodule

bind gpt_timers gpt_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .adc_trigger);
`default_nettype wire

/* verif/tb_general_purpose_timers.sv */
// Self-checking bench for the general purpose timers.
`timescale 1ns/1ns
`default_nettype none

module tb_general_purpose_timers;
  import gpt_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic        cpu_idle = 1'b0;
  logic [4:0]  tmr_ext_in = 5'h00;
  logic        irq;
  logic        adc_trigger;
  logic [15:0] tb_low;
  logic [15:0] tb_high;
  int          n_fail = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          n_adc = 0;
  logic [31:0] d;
  logic [1:0]  r;
  logic [15:0] v;

  gpt_timers dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_idle, .tmr_ext_in,
    .irq, .adc_trigger, .tb_low, .tb_high);

  // Clock, trigger counter and a ceiling on the run length.
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (adc_trigger === 1'b1) n_adc++;
    if (cycles == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Bus write: both channels offered together, held until taken.
  task automatic wr(input logic [7:0] a, input logic [15:0] dv,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, dv};
    s_axi_wstrb <= 4'h3;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_wstrb <= 4'h0;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    rd(a);
    chk("rdata", e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  // Follows the pair_b_low count cycle by cycle against its period.
  task automatic steps(input int n, input logic [15:0] per);
    logic [15:0] p;
    @(posedge aclk);
    p = tb_low;
    repeat (n) begin
      @(posedge aclk);
      chk("step", (p == per) ? 16'h0 : p + 16'h1, tb_low);
      p = tb_low;
    end
  endtask

  task automatic edges(input int b, input int n);
    repeat (n) begin
      @(posedge aclk);
      tmr_ext_in[b] <= 1'b1;
      cyc(3);
      tmr_ext_in[b] <= 1'b0;
      cyc(3);
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rc(8'h04, 32'hffff, RESP_OKAY);
    rc(8'h00, 32'h0, RESP_OKAY);
    rc(OFS_STATUS, 32'h0, RESP_OKAY);
    rc(8'h60, 32'h0, RESP_SLVERR);
    wr(8'h60, 16'h1234, RESP_SLVERR);
    chk("irq", 0, irq);
    $display("test reset done");
  endtask

  task automatic t_timer();
    wr(8'h04, 16'h0003, RESP_OKAY);
    wr(8'h00, 16'h8000, RESP_OKAY);
    cyc(10);
    chk("irq masked", 0, irq);
    wr(OFS_MASK, 16'h0001, RESP_OKAY);
    cyc(3);
    chk("irq", 1, irq);
    wr(8'h00, 16'h0000, RESP_OKAY);
    rc(OFS_STATUS, 32'h1, RESP_OKAY);
    rc(OFS_STATUS, 32'h0, RESP_OKAY);
    cyc(2);
    chk("irq clear", 0, irq);
    $display("test timer done");
  endtask

  task automatic t_idle();
    wr(8'h14, 16'h0004, RESP_OKAY);
    wr(8'h10, 16'ha000, RESP_OKAY);
    cyc(3);
    steps(12, 16'h0004);
    cpu_idle <= 1'b1;
    cyc(3);
    v = tb_low;
    cyc(5);
    chk("halted", v, tb_low);
    cpu_idle <= 1'b0;
    cyc(3);
    chk("resumed", 1, tb_low != v);
    wr(8'h10, 16'h8000, RESP_OKAY);
    cpu_idle <= 1'b1;
    cyc(3);
    steps(8, 16'h0004);
    cpu_idle <= 1'b0;
    $display("test idle done");
  endtask

  task automatic t_sync();
    wr(8'h20, 16'h8002, RESP_OKAY);
    edges(2, 4);
    cyc(5);
    chk("sync count", 16'h0004, tb_high);
    wr(8'h20, 16'h8012, RESP_OKAY);
    edges(2, 16);
    cyc(5);
    chk("prescaled", 16'h0006, tb_high);
    // One shared pin edge: the low timer steps one cycle after the high.
    wr(8'h20, 16'h8002, RESP_OKAY);
    wr(8'h10, 16'h8002, RESP_OKAY);
    @(posedge aclk);
    v = tb_low;
    tmr_ext_in[2:1] <= 2'h3;
    do @(posedge aclk); while (tb_high == 16'h0006);
    chk("low lag", v, tb_low);
    @(posedge aclk);
    tmr_ext_in[2:1] <= 2'h0;
    chk("low next", (v == 16'h0004) ? 16'h0 : v + 16'h1, tb_low);
    $display("test sync done");
  endtask

  task automatic t_async();
    wr(8'h08, 16'h0000, RESP_OKAY);
    wr(8'h00, 16'h8002, RESP_OKAY);
    edges(0, 3);
    rc(8'h08, 32'h3, RESP_OKAY);
    wr(8'h00, 16'ha002, RESP_OKAY);
    cpu_idle <= 1'b1;
    edges(0, 2);
    rc(8'h08, 32'h3, RESP_OKAY);
    cpu_idle <= 1'b0;
    edges(0, 1);
    rc(8'h08, 32'h0, RESP_OKAY);
    $display("test async done");
  endtask

  task automatic t_chain();
    int a0;
    wr(8'h10, 16'h0008, RESP_OKAY);
    wr(8'h14, 16'h0005, RESP_OKAY);
    wr(8'h24, 16'h0002, RESP_OKAY);
    wr(OFS_HOLD_B, 16'h0002, RESP_OKAY);
    wr(8'h18, 16'h0003, RESP_OKAY);
    chk("high load", 16'h0002, tb_high);
    chk("low load", 16'h0003, tb_low);
    wr(OFS_HOLD_B, 16'h0007, RESP_OKAY);
    rc(8'h18, 32'h3, RESP_OKAY);
    rc(OFS_HOLD_B, 32'h2, RESP_OKAY);
    rd(OFS_STATUS);
    wr(OFS_MASK, 16'h0004, RESP_OKAY);
    a0 = n_adc;
    wr(8'h10, 16'h8008, RESP_OKAY);
    for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge aclk);
    chk("chain irq", 1, irq);
    wr(8'h10, 16'h0008, RESP_OKAY);
    rc(OFS_STATUS, 32'h4, RESP_OKAY);
    chk("adc", 1, n_adc > a0);
    $display("test chain done");
  endtask

  task automatic t_gate();
    wr(8'h34, 16'h0003, RESP_OKAY);
    wr(8'h30, 16'h8040, RESP_OKAY);
    @(posedge aclk);
    tmr_ext_in[3] <= 1'b1;
    cyc(10);
    tmr_ext_in[3] <= 1'b0;
    cyc(8);
    rc(OFS_STATUS, 32'h8, RESP_OKAY);
    rd(8'h38);
    chk("no clear", 32'ha, d);
    $display("test gate done");
  endtask

  // Chained pair_c as a 32-bit synchronized counter; high control unused.
  task automatic t_chain_c();
    wr(8'h30, 16'h0008, RESP_OKAY);
    wr(8'h34, 16'h0000, RESP_OKAY);
    wr(8'h44, 16'h0001, RESP_OKAY);
    wr(8'h40, 16'h8000, RESP_OKAY);
    wr(OFS_HOLD_C, 16'h0000, RESP_OKAY);
    wr(8'h38, 16'hffff, RESP_OKAY);
    wr(8'h30, 16'h800a, RESP_OKAY);
    edges(3, 1);
    rc(8'h38, 32'h0, RESP_OKAY);
    rc(OFS_HOLD_C, 32'h1, RESP_OKAY);
    rd(OFS_STATUS);
    edges(3, 1);
    rc(OFS_STATUS, 32'h10, RESP_OKAY);
    rc(OFS_STATUS, 32'h0, RESP_OKAY);
    rc(8'h38, 32'h0, RESP_OKAY);
    $display("test chain c done");
  endtask

  // Main sequence: reset, the scenarios, then the verdict.
  initial begin
    cyc(8);
    aresetn <= 1'b1;
    t_reset();
    t_timer();
    t_idle();
    t_sync();
    t_async();
    t_chain();
    t_gate();
    t_chain_c();
    give_verdict();
  end
endmodule
`default_nettype wire
